// file: rtl/dpba_defines.svh
// register offsets, field positions, reset values and timing counts of the arbiter
`ifndef DPBA_DEFINES_SVH
`define DPBA_DEFINES_SVH

`define DPBA_ADDR_W         4
`define DPBA_DATA_W         32
`define DPBA_LIMIT_W        16
`define DPBA_OFF_LIMIT      4'h0
`define DPBA_OFF_CTRL       4'h4
`define DPBA_OFF_STATUS     4'h8
`define DPBA_OFF_COUNT      4'hc
`define DPBA_CTRL_LOCK      0
`define DPBA_CTRL_SOFT_RESET_BIT      1
`define DPBA_ST_MST_LSB     0
`define DPBA_ST_MST_MSB     1
`define DPBA_ST_SYNC        2
`define DPBA_ST_ISMST       3
`define DPBA_ID_SINGLE      2'h0
`define DPBA_ID_ONE         2'h1
`define DPBA_ID_TWO         2'h2
`define DPBA_ID_RSVD        2'h3
`define DPBA_HOLD_LIMIT_RST 16'h0012
`define DPBA_IGNORE_CYCLES  2'h2

`endif

// file: rtl/dpba_pkg.sv
// types shared by the dual processor bus arbiter
package dpba_pkg;
	typedef enum logic [2:0] {
		DPBA_RESET  = 3'b000,
		DPBA_POST1  = 3'b001,
		DPBA_POST2  = 3'b010,
		DPBA_UNSYNC = 3'b011,
		DPBA_SLAVE  = 3'b100,
		DPBA_MASTER = 3'b101,
		DPBA_SINGLE = 3'b110
	} dpba_state_t;
endpackage : dpba_pkg

// file: rtl/dpba_hold_counter.sv
// mastership hold counter: load, decrement, stop at zero
`timescale 1ns/10ps
`default_nettype none

module dpba_hold_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             mclk_in,
	input  wire logic             reset_n_in,
	input  wire logic             load_in,
	input  wire logic             dec_in,
	input  wire logic [WIDTH-1:0] limit_in,
	output logic      [WIDTH-1:0] count_out,
	output logic                  zero_out
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} dpba_cnt_st_t;

	dpba_cnt_st_t r_reg;
	dpba_cnt_st_t r_next;

	// load wins over decrement; the count sits at zero until reloaded
	always_comb begin
		r_next = r_reg;
		if (load_in) begin
			r_next.cnt = limit_in;
		end else if (dec_in && (r_reg.cnt != '0)) begin
			r_next.cnt = r_reg.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign count_out = r_reg.cnt;
	assign zero_out  = (r_reg.cnt == '0);
endmodule : dpba_hold_counter

`default_nettype wire

// file: rtl/dpba_prio_filter.sv
// priority line sampler with one cycle release lag and a post-acquire blind window
`timescale 1ns/10ps
`default_nettype none
`include "dpba_defines.svh"

module dpba_prio_filter (
	input  wire logic mclk_in,
	input  wire logic reset_n_in,
	input  wire logic prio_n_in,
	input  wire logic ignore_start_in,
	output logic      prio_active_out
);
	typedef struct packed {
		logic       samp_n;
		logic [1:0] ignore_cnt;
		logic       active;
	} dpba_flt_st_t;

	dpba_flt_st_t r_reg;
	dpba_flt_st_t r_next;

	// active follows the sample one cycle late, so a high sample frees us a cycle later
	always_comb begin
		r_next = r_reg;
		r_next.samp_n = prio_n_in;
		if (ignore_start_in) begin
			r_next.ignore_cnt = `DPBA_IGNORE_CYCLES;
		end else if (r_reg.ignore_cnt != 2'h0) begin
			r_next.ignore_cnt = r_reg.ignore_cnt - 2'h1;
		end
		r_next.active = !r_reg.samp_n && (r_next.ignore_cnt == 2'h0)
			&& (r_reg.ignore_cnt == 2'h0);
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			r_reg <= '{samp_n: 1'b1, ignore_cnt: 2'h0, active: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign prio_active_out = r_reg.active;
endmodule : dpba_prio_filter

`default_nettype wire

// file: rtl/dpba_arbiter.sv
// dual processor bus arbiter: reset synchronisation, hold timeout, priority override
`timescale 1ns/10ps
`default_nettype none
`include "dpba_defines.svh"

// Notes on behaviour
// - on hold timeout finish current access, then drop request, hold back new ones
// - timeout with other side idle: keep request, do not reload counter
// - an access stretched by acknowledge keeps mastership until it completes
// - under bus lock the timeout drop waits until lock clears
// - host bus request freezes the hold counter until withdrawn
// - without priority line, give bus only when idle or on timeout
// - non-master with pending core access pulls priority line and requests
// - priority line only pulled low, never by the current master
// - master without core access drops request on priority, after current access
// - while priority active, request only for a pending core access
// - new master lets go of the priority line at once
// - normal requesting resumes one cycle after priority sampled high
// - new master ignores the priority line for two cycles
// - soft reset resynchronises exactly like hardware reset
// - identity 00 runs single, no arbitration synchronisation
// - identity 10 keeps its request off in reset and two cycles after
// - synchronised when exactly one request is seen; it names the master
// - identity 01 requests in reset and two cycles after; drives control lines
// - identity 01 synced after two cycles becomes master, else drops out
// - sync done status set once synchronised
// - in reset identity 01 drives controls only if last cycle it alone held bus
// - identity 01 keeps driving two cycles after reset unless grant or other request
// - counter loads on gaining bus, decrements on contended accesses, reloads on drop
// - mastership passes only when master drops and other requests together
module dpba_arbiter
	import dpba_pkg::*;
#(
	parameter int LIMIT_W = `DPBA_LIMIT_W
) (
	input  wire logic                      mclk_in,
	input  wire logic                      reset_n_in,
	input  wire logic [1:0]                identity_strap_in,
	input  wire logic                      core_pending_in,
	input  wire logic                      dma_pending_in,
	input  wire logic                      access_active_in,
	input  wire logic                      access_busy_in,
	input  wire logic                      ack_hold_in,
	input  wire logic                      other_request_n_in,
	input  wire logic                      host_bus_request_n_in,
	input  wire logic                      host_bus_grant_n_in,
	input  wire logic                      priority_override_line_n_in,
	input  wire logic [`DPBA_ADDR_W-1:0]   reg_addr_in,
	input  wire logic [`DPBA_DATA_W-1:0]   reg_wdata_in,
	input  wire logic                      reg_wr_in,
	input  wire logic                      reg_rd_in,
	output logic                           bus_request_line_n_out,
	output logic                           priority_override_line_out,
	output logic                           priority_override_line_oe_out,
	output logic                           is_master_out,
	output logic                           access_grant_out,
	output logic                           memctl_drive_out,
	output logic [`DPBA_DATA_W-1:0]        reg_rdata_out
);
	typedef struct packed {
		dpba_state_t                 state;
		logic [1:0]                  id;
		logic                        own_req_n;
		logic                        own_prev_n;
		logic                        oth_n;
		logic                        hbr_n;
		logic                        hbg_n;
		logic                        sync;
		logic [1:0]                  master_id;
		logic                        cpa_oe;
		logic                        grant;
		logic                        memctl;
		logic                        is_master;
		logic [LIMIT_W-1:0]          limit;
		logic                        lock;
		logic                        soft_reset_bit;
		logic [`DPBA_DATA_W-1:0]     rdata;
	} dpba_arb_st_t;

	dpba_arb_st_t       r_reg;
	dpba_arb_st_t       r_next;
	logic               in_rst;
	logic               one_line;
	logic               want;
	logic               req_ok;
	logic               tout;
	logic               rel_hold;
	logic               drop;
	logic               gain;
	logic               cnt_load;
	logic               cnt_dec;
	logic               cnt_zero;
	logic               prio_active;
	logic [LIMIT_W-1:0] cnt;

	// identity of the other processor of the pair
	function automatic logic [1:0] dpba_other_id(input logic [1:0] id);
		dpba_other_id = (id == `DPBA_ID_ONE) ? `DPBA_ID_TWO : `DPBA_ID_ONE;
	endfunction : dpba_other_id

	// single processor straps, including the reserved one
	function automatic logic dpba_is_single(input logic [1:0] id);
		dpba_is_single = (id == `DPBA_ID_SINGLE) || (id == `DPBA_ID_RSVD);
	endfunction : dpba_is_single

	// software pulse and hardware pin both hold the arbiter in reset
	assign in_rst   = !reset_n_in || r_reg.soft_reset_bit;
	// own line is taken one cycle late so both lines describe the same bus cycle
	assign one_line = (!r_reg.own_prev_n) ^ (!r_reg.oth_n);
	assign want     = core_pending_in || dma_pending_in;
	assign req_ok   = prio_active ? core_pending_in : want;
	assign tout     = cnt_zero && !r_reg.oth_n;
	assign rel_hold = (tout && !r_reg.lock) || (prio_active && !core_pending_in);
	assign drop     = (rel_hold || !want) && !access_busy_in && !ack_hold_in;
	assign gain     = (r_reg.state == DPBA_SLAVE) && !r_reg.own_prev_n && r_reg.oth_n;

	// counter control: load on gain or while master with our request off, count contended accesses
	assign cnt_load = gain || ((r_reg.state == DPBA_MASTER) && r_reg.own_req_n);
	assign cnt_dec  = (r_reg.state == DPBA_MASTER) && !r_reg.own_req_n && access_active_in
		&& !r_reg.oth_n && r_reg.hbr_n;

	dpba_hold_counter #(
		.WIDTH(LIMIT_W)
	) u_hold_counter (
		.mclk_in   (mclk_in),
		.reset_n_in(!in_rst),
		.load_in   (cnt_load),
		.dec_in    (cnt_dec),
		.limit_in  (r_reg.limit),
		.count_out (cnt),
		.zero_out  (cnt_zero)
	);

	dpba_prio_filter u_prio_filter (
		.mclk_in        (mclk_in),
		.reset_n_in     (!in_rst),
		.prio_n_in      (priority_override_line_n_in),
		.ignore_start_in(gain),
		.prio_active_out(prio_active)
	);

	// arbitration state machine plus register port
	always_comb begin
		r_next = r_reg;
		r_next.oth_n = other_request_n_in;
		r_next.own_prev_n = r_reg.own_req_n; // line level matching the other sample
		r_next.hbr_n = host_bus_request_n_in;
		r_next.hbg_n = host_bus_grant_n_in;
		r_next.soft_reset_bit  = 1'b0;
		r_next.rdata = '0;
		if (in_rst) begin
			r_next.state     = DPBA_RESET;
			r_next.id        = identity_strap_in;
			r_next.own_req_n = (identity_strap_in != `DPBA_ID_ONE);
			r_next.sync      = 1'b0;
			r_next.master_id = `DPBA_ID_SINGLE;
			r_next.cpa_oe    = 1'b0;
			r_next.grant     = 1'b0;
			r_next.is_master = 1'b0;
			r_next.memctl    = (identity_strap_in == `DPBA_ID_ONE) && !r_reg.own_req_n
				&& r_reg.oth_n && r_reg.hbg_n;
		end else begin
			case (r_reg.state)
				DPBA_RESET: begin
					if (dpba_is_single(r_reg.id)) begin
						r_next.state     = DPBA_SINGLE;
						r_next.master_id = r_reg.id;
						r_next.is_master = 1'b1;
						r_next.grant     = 1'b1;
						r_next.memctl    = 1'b1;
					end else begin
						r_next.state  = DPBA_POST1;
						r_next.memctl = r_reg.memctl && other_request_n_in
							&& host_bus_grant_n_in;
					end
				end
				DPBA_POST1, DPBA_POST2: begin
					r_next.memctl = r_reg.memctl && other_request_n_in
						&& host_bus_grant_n_in;
					if (!r_reg.sync && one_line) begin
						r_next.sync      = 1'b1;
						r_next.master_id = !r_reg.own_prev_n ? r_reg.id : dpba_other_id(r_reg.id);
					end
					if (r_reg.state == DPBA_POST1) begin
						r_next.state = DPBA_POST2;
					end else if (r_next.sync && (r_next.master_id == r_reg.id)) begin
						r_next.state     = DPBA_MASTER;
						r_next.is_master = 1'b1;
						r_next.grant     = 1'b1;
						r_next.memctl    = 1'b1;
					end else begin
						r_next.state     = r_next.sync ? DPBA_SLAVE : DPBA_UNSYNC;
						r_next.own_req_n = 1'b1;
						r_next.memctl    = 1'b0;
					end
				end
				DPBA_UNSYNC: begin
					r_next.own_req_n = 1'b1;
					if (one_line) begin
						r_next.sync      = 1'b1;
						r_next.master_id = dpba_other_id(r_reg.id);
						r_next.state     = DPBA_SLAVE;
					end
				end
				DPBA_SLAVE: begin
					if (gain) begin
						r_next.state     = DPBA_MASTER;
						r_next.master_id = r_reg.id;
						r_next.is_master = 1'b1;
						r_next.cpa_oe    = 1'b0;
						r_next.grant     = want;
						r_next.memctl    = 1'b1;
					end else begin
						r_next.own_req_n = !req_ok;
						r_next.cpa_oe    = core_pending_in;
					end
				end
				DPBA_MASTER: begin
					r_next.cpa_oe = 1'b0;
					// a transition needs our line off and the other on in the same cycle
					if (r_reg.own_req_n) begin
						if (r_reg.own_prev_n && !r_reg.oth_n) begin
							r_next.state     = DPBA_SLAVE;
							r_next.master_id = dpba_other_id(r_reg.id);
							r_next.is_master = 1'b0;
							r_next.memctl    = 1'b0;
							r_next.grant     = 1'b0;
						end else if (req_ok && r_reg.oth_n) begin
							r_next.own_req_n = 1'b0;
							r_next.grant     = 1'b1;
						end
					end else begin
						r_next.own_req_n = drop;
						r_next.grant     = !drop && !rel_hold;
					end
				end
				DPBA_SINGLE: begin
					r_next.grant  = 1'b1;
					r_next.memctl = 1'b1;
				end
				default: begin
					r_next.state = DPBA_RESET;
				end
			endcase
		end
		// register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				`DPBA_OFF_LIMIT: r_next.limit = reg_wdata_in[LIMIT_W-1:0];
				`DPBA_OFF_CTRL: begin
					r_next.lock = reg_wdata_in[`DPBA_CTRL_LOCK];
					r_next.soft_reset_bit = reg_wdata_in[`DPBA_CTRL_SOFT_RESET_BIT];
				end
				default: r_next.soft_reset_bit = 1'b0;
			endcase
		end
		// register reads, answered in the following cycle
		if (reg_rd_in) begin
			case (reg_addr_in)
				`DPBA_OFF_LIMIT: r_next.rdata[LIMIT_W-1:0] = r_reg.limit;
				`DPBA_OFF_CTRL:  r_next.rdata[`DPBA_CTRL_LOCK] = r_reg.lock;
				`DPBA_OFF_STATUS: begin
					r_next.rdata[`DPBA_ST_MST_MSB:`DPBA_ST_MST_LSB] = r_reg.master_id;
					r_next.rdata[`DPBA_ST_SYNC]  = r_reg.sync;
					r_next.rdata[`DPBA_ST_ISMST] = r_reg.is_master;
				end
				`DPBA_OFF_COUNT: r_next.rdata[LIMIT_W-1:0] = cnt;
				default:         r_next.rdata = '0;
			endcase
		end
	end

	// state register; limit and lock survive a soft reset
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			r_reg           <= '0;
			r_reg.state     <= DPBA_RESET;
			r_reg.id        <= identity_strap_in;
			r_reg.own_req_n <= (identity_strap_in != `DPBA_ID_ONE);
			r_reg.own_prev_n <= (identity_strap_in != `DPBA_ID_ONE);
			r_reg.oth_n     <= 1'b1;
			r_reg.hbr_n     <= 1'b1;
			r_reg.hbg_n     <= 1'b1;
			r_reg.memctl    <= (identity_strap_in == `DPBA_ID_ONE) && !r_reg.own_req_n
				&& r_reg.oth_n && r_reg.hbg_n;
			r_reg.limit     <= `DPBA_HOLD_LIMIT_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign bus_request_line_n_out        = r_reg.own_req_n;
	assign priority_override_line_out    = 1'b0;
	assign priority_override_line_oe_out = r_reg.cpa_oe;
	assign is_master_out                 = r_reg.is_master;
	assign access_grant_out              = r_reg.grant;
	assign memctl_drive_out              = r_reg.memctl;
	assign reg_rdata_out                 = r_reg.rdata;

	default clocking dpba_cb @(posedge mclk_in); endclocking
	default disable iff (in_rst);

	a_busy_keeps_req: assert property (
		(r_reg.state == DPBA_MASTER && !r_reg.own_req_n && (access_busy_in || ack_hold_in))
		|=> !r_reg.own_req_n)
		else $error("request dropped during an unfinished access");
	a_lock_holds_req: assert property (
		(r_reg.state == DPBA_MASTER && !r_reg.own_req_n && tout && r_reg.lock && want
		&& !prio_active) |=> !r_reg.own_req_n)
		else $error("request dropped under bus lock");
	a_idle_no_reload: assert property (
		(r_reg.state == DPBA_MASTER && !r_reg.own_req_n && cnt_zero && r_reg.oth_n && want
		&& !prio_active) |=> (!r_reg.own_req_n && cnt_zero))
		else $error("counter reloaded or request dropped with no contender");
	a_host_freeze: assert property (
		(r_reg.state == DPBA_MASTER && !r_reg.own_req_n && !r_reg.hbr_n)
		##1 (r_reg.state == DPBA_MASTER && !r_reg.own_req_n) |-> $stable(cnt))
		else $error("counter moved during host request");
	a_master_no_prio: assert property (
		(r_reg.state == DPBA_MASTER || r_reg.state == DPBA_SINGLE) |-> !r_reg.cpa_oe)
		else $error("master pulls the priority line");
	a_gain_release_prio: assert property (
		gain |=> (!r_reg.cpa_oe && r_reg.state == DPBA_MASTER) ##1 !prio_active ##1 !prio_active)
		else $error("new master kept priority line or listened too early");
	a_slave_prio_req: assert property (
		(r_reg.state == DPBA_SLAVE && !gain && core_pending_in)
		|=> (r_reg.cpa_oe && !r_reg.own_req_n))
		else $error("pending core access did not pull priority and request");
	a_prio_drop: assert property (
		(r_reg.state == DPBA_MASTER && !r_reg.own_req_n && prio_active && !core_pending_in
		&& !access_busy_in && !ack_hold_in) |=> r_reg.own_req_n)
		else $error("master kept request under priority");
	a_id_two_quiet: assert property (
		(r_reg.id == `DPBA_ID_TWO && (r_reg.state == DPBA_POST1 || r_reg.state == DPBA_POST2))
		|-> r_reg.own_req_n)
		else $error("identity two requested before sync window ended");
	a_id_one_request: assert property (
		(r_reg.id == `DPBA_ID_ONE && r_reg.state == DPBA_POST1) |-> !r_reg.own_req_n)
		else $error("identity one released request too early");
	a_sync_cause: assert property (
		$rose(r_reg.sync) |-> $past(one_line))
		else $error("sync set without a single request line");
	a_drive_window: assert property (
		(r_reg.state == DPBA_POST2 && r_reg.memctl) |-> ($past(r_reg.memctl)
		&& r_reg.oth_n && r_reg.hbg_n))
		else $error("control lines driven despite grant or other request");
endmodule : dpba_arbiter

`default_nettype wire

// file: verification/dpba_peer.sv
// behavioural model of the second processor sharing the external bus
`timescale 1ns/10ps
`default_nettype none

module dpba_peer (
	input  wire logic mclk_in,
	input  wire logic reset_n_in,
	input  wire logic want_in,
	input  wire logic core_in,
	input  wire logic dut_request_n_in,
	input  wire logic prio_n_in,
	output logic      request_n_out,
	output logic      prio_oe_out,
	output logic      master_out
);
	logic master_nx;
	logic prio_other;

	// mastership passes only when the arbiter lets go while we request
	// a master keeps the bus unless it drops while the arbiter requests
	assign master_nx = master_out ? ~(request_n_out & ~dut_request_n_in)
		: (~request_n_out & dut_request_n_in);
	// priority pulled by the other side, not by us
	assign prio_other = ~prio_n_in & ~prio_oe_out;

	// request line, priority pull and mastership record
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			request_n_out <= 1'b1;
			prio_oe_out   <= 1'b0;
			master_out    <= 1'b0;
		end else begin
			// under priority only a core access may request; idle master yields
			request_n_out <= ~(want_in & ~(prio_other & ~core_in));
			// core access of a non-master pulls the shared line low only
			prio_oe_out   <= core_in & want_in & ~master_nx;
			master_out    <= master_nx;
		end
	end
endmodule : dpba_peer

`default_nettype wire

// file: verification/dual_processor_bus_arbitration_bench.sv
// self-checking bench of the bus arbiter facing a model of the second processor
`timescale 1ns/10ps
`default_nettype none
`include "dpba_defines.svh"

module dual_processor_bus_arbitration_bench;
	logic        mclk_in    = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [1:0]  strap      = 2'h1;
	logic        core_pend  = 1'b0;
	logic        active     = 1'b0;
	logic        host_req_n = 1'b1;
	logic [3:0]  addr       = 4'h0;
	logic [31:0] wdata      = 32'h0;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic        want       = 1'b0;
	logic        peer_core  = 1'b0;
	logic        rd_mark    = 1'b0;
	logic        req_n, prio_out, prio_oe, is_mst, grant, memctl;
	logic        peer_req_n, peer_oe, peer_mst;
	logic [31:0] rdata;
	logic [31:0] exp_q[$];
	int          n_errors     = 0;
	int          total_checks = 0;
	int          seed         = 33;
	int          limit;
	// shared priority line with pull-up, either side may pull it low
	wire         prio_n = ~((prio_oe & ~prio_out) | peer_oe);

	always #5 mclk_in = ~mclk_in;

	dpba_arbiter u_dut (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .identity_strap_in(strap),
		.core_pending_in(core_pend), .dma_pending_in(want), .access_active_in(active),
		.access_busy_in(1'b0), .ack_hold_in(1'b0), .other_request_n_in(peer_req_n),
		.host_bus_request_n_in(host_req_n), .host_bus_grant_n_in(1'b1),
		.priority_override_line_n_in(prio_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .bus_request_line_n_out(req_n),
		.priority_override_line_out(prio_out), .priority_override_line_oe_out(prio_oe),
		.is_master_out(is_mst), .access_grant_out(grant), .memctl_drive_out(memctl),
		.reg_rdata_out(rdata)
	);

	dpba_peer u_peer (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .want_in(want), .core_in(peer_core),
		.dut_request_n_in(req_n), .prio_n_in(prio_n), .request_n_out(peer_req_n),
		.prio_oe_out(peer_oe), .master_out(peer_mst)
	);

	// compare one value and count it
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// wait a bounded number of cycles for a level, then compare
	task automatic wait_lvl(input string nm, ref logic s, input logic v, input int lim);
		int i;
		@(negedge mclk_in);
		for (i = 0; i < lim && s !== v; i++) @(negedge mclk_in);
		chk(nm, 32'(v), 32'(s));
	endtask : wait_lvl

	// one-cycle register write
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk_in);
		wr    <= 1'b0;
	endtask : reg_wr

	// one-cycle register read, expected answer noted for the monitor
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk_in);
		rd   <= 1'b0;
	endtask : reg_rd

	// two reset edges, then release; ends in the last reset cycle
	task automatic reset_dut(input logic [1:0] s);
		@(posedge mclk_in);
		reset_n_in <= 1'b0;
		strap      <= s;
		@(posedge mclk_in);
		@(posedge mclk_in);
		reset_n_in <= 1'b1;
		@(negedge mclk_in);
	endtask : reset_dut

	// read answers stand only in the cycle after the strobe
	always @(negedge mclk_in) begin
		if (rd_mark) begin
			chk("read data", exp_q.pop_front(), rdata);
		end
		rd_mark = rd;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	// main sequence
	initial begin
		reset_dut(2'h1);
		chk("request in reset", 32'h0, 32'(req_n));
		chk("memctl in reset", 32'h1, 32'(memctl));
		@(negedge mclk_in);
		chk("memctl after reset", 32'h1, 32'(memctl));
		wait_lvl("master after sync", is_mst, 1'b1, 4);
		reg_rd(`DPBA_OFF_STATUS, 32'hd);
		reg_rd(`DPBA_OFF_LIMIT, 32'h12);
		reg_rd(4'h2, 32'h0);
		$display("test reset sync finished");
		limit = 4 + ($random(seed) & 3);
		reg_wr(`DPBA_OFF_LIMIT, 32'(limit));
		reg_wr(`DPBA_OFF_CTRL, 32'h2);
		wait_lvl("master off in soft reset", is_mst, 1'b0, 3);
		wait_lvl("master after resync", is_mst, 1'b1, 6);
		reg_rd(`DPBA_OFF_LIMIT, 32'(limit));
		$display("test soft reset finished");
		reg_wr(`DPBA_OFF_CTRL, 32'h1);
		@(posedge mclk_in);
		host_req_n <= 1'b0;
		active     <= 1'b1;
		want       <= 1'b1;
		repeat (3) @(posedge mclk_in);
		reg_rd(`DPBA_OFF_COUNT, 32'(limit));
		@(posedge mclk_in);
		host_req_n <= 1'b1;
		repeat (limit + 4) @(posedge mclk_in);
		reg_rd(`DPBA_OFF_COUNT, 32'h0);
		@(negedge mclk_in);
		chk("request under lock", 32'h0, 32'(req_n));
		reg_wr(`DPBA_OFF_CTRL, 32'h0);
		wait_lvl("request after timeout", req_n, 1'b1, 4);
		chk("grant after timeout", 32'h0, 32'(grant));
		wait_lvl("master lost", is_mst, 1'b0, 4);
		chk("peer master after timeout", 32'h1, 32'(peer_mst));
		reg_rd(`DPBA_OFF_STATUS, 32'h6);
		reg_rd(`DPBA_OFF_COUNT, 32'(limit));
		$display("test hold timeout finished");
		@(posedge mclk_in);
		active    <= 1'b0;
		core_pend <= 1'b1;
		wait_lvl("priority pulled", prio_oe, 1'b1, 4);
		chk("request with priority", 32'h0, 32'(req_n));
		wait_lvl("master by priority", is_mst, 1'b1, 8);
		chk("peer master by arbiter priority", 32'h0, 32'(peer_mst));
		wait_lvl("priority let go", prio_oe, 1'b0, 2);
		@(posedge mclk_in);
		core_pend <= 1'b0;
		want      <= 1'b0;
		wait_lvl("idle master yields", req_n, 1'b1, 6);
		$display("test priority finished");
		// the peer's core pulls priority while the arbiter masters with only dma work
		@(posedge mclk_in);
		want      <= 1'b1;
		peer_core <= 1'b1;
		wait_lvl("master yields to priority", is_mst, 1'b0, 10);
		chk("peer master by peer priority", 32'h1, 32'(peer_mst));
		$display("test peer priority finished");
		@(posedge mclk_in);
		want      <= 1'b0;
		peer_core <= 1'b0;
		reset_dut(2'h2);
		chk("id two request in reset", 32'h1, 32'(req_n));
		repeat (2) begin
			@(negedge mclk_in);
			chk("id two request after reset", 32'h1, 32'(req_n));
		end
		reset_dut(2'h0);
		wait_lvl("single master", is_mst, 1'b1, 3);
		chk("single grant", 32'h1, 32'(grant));
		chk("single memctl", 32'h1, 32'(memctl));
		$display("test straps finished");
		repeat (3) @(negedge mclk_in);
		chk("reads answered", 32'h0, 32'(exp_q.size()));
		complete_run();
	end

	// watchdog against a hung run
	initial begin
		#200000;
		n_errors++;
		$display("MISMATCH watchdog expected finish seen timeout");
		complete_run();
	end
endmodule : dual_processor_bus_arbitration_bench

`default_nettype wire
